// >>> design/hbp_device_end.sv
// Device end: bus style detection, address capture, byte lanes and tri-state data
// Contract
// - Data lines driven only for read data
// - Address inputs pick the target register
// - Lowest address pin is address LSB
// - Byte enables choose lanes in strobe style
// - Active-low upper/lower strobes in direction style
// - Style pin static high: direction-line style
// - Style pin static low: separate-strobe style
// - Style pin falling edge selects multiplexed style
// - Address captured on latch enable fall
// - Width pin selects 8 or 16 bit
// - Strobes ignored while chip select high
// - Read strobe reads, write strobe writes
// - Acknowledge held until strobe/select release
`timescale 1ns/1ps
`default_nettype none
module hbp_device_end
  import hbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WORD_IDX_W-1:0] peekIdx,
  output logic [DATA_W-1:0] peekData,
  output hbp_style_t styleNow,
  output logic wrPulse,
  output logic [WORD_IDX_W-1:0] wrIdx,
  output logic [LANE_COUNT-1:0] wrLanes,
  output logic rdPulse,
  hbp_if.device bus
);
  typedef enum logic {D_IDLE, D_ACK} hbp_dstate_t;
  hbp_dstate_t state_reg;
  logic stylePinPrev_reg;
  logic muxMode_reg;
  logic [ADDR_W-1:0] latchedAddr_reg;
  logic [DATA_W-1:0] regFile [WORD_COUNT];

  logic styleFall;
  hbp_style_t style;
  logic [ADDR_W-1:0] addrEff;
  logic [WORD_IDX_W-1:0] wordIdx;
  logic strobeAct;
  logic isRead;
  logic [LANE_COUNT-1:0] lanes;
  logic accessActive;
  logic accessReq;
  logic [DATA_W-1:0] readWord;
  logic [DATA_W-1:0] readOut;
  logic [DATA_W-1:0] writeIn;

  assign styleFall = stylePinPrev_reg && !bus.busStyleSel;

  always_ff @(posedge clk) begin
    if (rst) begin
      stylePinPrev_reg <= STYLE_PIN_PRESET;
    end else if (ce) begin
      stylePinPrev_reg <= bus.busStyleSel;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      muxMode_reg <= 1'h0;
    end else if (ce && styleFall) begin
      muxMode_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latchedAddr_reg <= ADDR_RESET;
    end else if (ce && styleFall) begin
      latchedAddr_reg <= bus.addr;
    end
  end

  always_comb begin
    if (muxMode_reg) begin
      style = HBP_STYLE_MUX;
    end else if (bus.busStyleSel == STYLE_PIN_DIRLINE) begin
      style = HBP_STYLE_DIRLINE;
    end else begin
      style = HBP_STYLE_STROBE;
    end
  end

  always_comb begin
    addrEff = (style == HBP_STYLE_MUX) ? latchedAddr_reg : bus.addr;
    wordIdx = addrEff[ADDR_W-1:ADDR_LSB+1];
    strobeAct = 1'h0;
    isRead = 1'h0;
    lanes = LANES_NONE;
    unique case (style)
      HBP_STYLE_DIRLINE: begin
        isRead = bus.rwN;
        if (bus.widthSel) begin
          strobeAct = !bus.addr[ADDR_LSB] || !bus.strobeHighN;
          lanes[LANE_HI] = !bus.addr[ADDR_LSB];
          lanes[LANE_LO] = !bus.strobeHighN;
        end else begin
          strobeAct = !bus.strobeHighN;
        end
      end
      HBP_STYLE_STROBE, HBP_STYLE_MUX: begin
        strobeAct = !bus.rdN || !bus.wrN;
        isRead = !bus.rdN;
        if (bus.widthSel) begin
          lanes[LANE_LO] = !bus.addr[ADDR_LSB];
          lanes[LANE_HI] = !bus.strobeHighN;
        end
      end
    endcase
    // Byte mode lane from address LSB
    if (!bus.widthSel) begin
      lanes = addrEff[ADDR_LSB] ? LANES_HI_ONLY : LANES_LO_ONLY;
    end
  end

  assign accessActive = !bus.csN && strobeAct;
  assign accessReq = accessActive && (lanes != LANES_NONE) && (state_reg == D_IDLE);

  always_comb begin
    readWord = regFile[wordIdx];
    readOut = readWord;
    writeIn = bus.dataBus;
    // Byte mode always travels on the low lane
    if (!bus.widthSel) begin
      readOut = {BYTE_ZERO, lanes[LANE_HI] ? readWord[DATA_W-1:BYTE_W] : readWord[BYTE_W-1:0]};
      writeIn = {bus.dataBus[BYTE_W-1:0], bus.dataBus[BYTE_W-1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (ce && accessReq && !isRead) begin
      for (int i = 0; i < LANE_COUNT; i++) begin
        if (lanes[i]) begin
          regFile[wordIdx][i*BYTE_W +: BYTE_W] <= writeIn[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= D_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        D_IDLE: begin
          if (accessReq) begin
            state_reg <= D_ACK;
          end
        end
        D_ACK: begin
          if (!accessActive) begin
            state_reg <= D_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.transferAckN <= PULL_LEVEL;
      bus.ackOe <= 1'h0;
    end else if (ce) begin
      if (accessReq) begin
        bus.transferAckN <= 1'h0;
        bus.ackOe <= 1'h1;
      end else if (state_reg == D_ACK && !accessActive) begin
        bus.transferAckN <= PULL_LEVEL;
        bus.ackOe <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.devData <= DATA_RESET;
      bus.devDataOe <= 1'h0;
    end else if (ce) begin
      if (accessReq && isRead) begin
        bus.devData <= readOut;
        bus.devDataOe <= 1'h1;
      end else if (state_reg == D_ACK && !accessActive) begin
        bus.devDataOe <= 1'h0;
      end
    end
  end

  // Event pulses let the core beside this port see accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPulse <= 1'h0;
      rdPulse <= 1'h0;
      wrIdx <= WORD_IDX_RESET;
      wrLanes <= LANES_NONE;
      styleNow <= HBP_STYLE_STROBE;
      peekData <= DATA_RESET;
    end else if (ce) begin
      wrPulse <= accessReq && !isRead;
      rdPulse <= accessReq && isRead;
      if (accessReq && !isRead) begin
        wrIdx <= wordIdx;
        wrLanes <= lanes;
      end
      styleNow <= style;
      peekData <= regFile[peekIdx];
    end
  end
endmodule
`default_nettype wire

// >>> design/hbp_host_end.sv
// Bus master end: runs one register access per command in the chosen bus style
`timescale 1ns/1ps
`default_nettype none
module hbp_host_end
  import hbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire hbp_style_t styleSel,
  input wire logic wideSel,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdData,
  input wire logic [LANE_COUNT-1:0] cmdLanes,
  output logic cmdReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  hbp_if.host bus
);
  typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_WAIT, H_END} hbp_hstate_t;
  hbp_hstate_t state_reg;
  logic write_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [LANE_COUNT-1:0] lanes_reg;
  logic take;

  assign take = cmdValid && cmdReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= H_IDLE;
      cmdReady <= 1'h0;
      write_reg <= 1'h0;
      addr_reg <= ADDR_RESET;
      data_reg <= DATA_RESET;
      lanes_reg <= LANES_NONE;
    end else if (ce) begin
      unique case (state_reg)
        H_IDLE: begin
          cmdReady <= 1'h1;
          if (take) begin
            cmdReady <= 1'h0;
            write_reg <= cmdWrite;
            addr_reg <= cmdAddr;
            data_reg <= cmdData;
            lanes_reg <= cmdLanes;
            state_reg <= (styleSel == HBP_STYLE_MUX) ? H_ALE : H_SETUP;
          end
        end
        H_ALE: state_reg <= H_SETUP;
        H_SETUP: state_reg <= H_WAIT;
        H_WAIT: begin
          if (!bus.ackLine) begin
            state_reg <= H_END;
          end
        end
        H_END: state_reg <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.busStyleSel <= STYLE_PIN_PRESET;
      bus.widthSel <= 1'h0;
      bus.csN <= PULL_LEVEL;
      bus.rdN <= PULL_LEVEL;
      bus.wrN <= PULL_LEVEL;
      bus.rwN <= PULL_LEVEL;
      bus.strobeHighN <= PULL_LEVEL;
      bus.addr <= ADDR_RESET;
      bus.hostData <= DATA_RESET;
      bus.hostDataOe <= 1'h0;
    end else if (ce) begin
      bus.widthSel <= wideSel;
      if (state_reg == H_IDLE) begin
        bus.busStyleSel <= (styleSel == HBP_STYLE_DIRLINE) ? STYLE_PIN_DIRLINE : STYLE_PIN_STROBE;
      end
      if (state_reg == H_ALE) begin
        bus.busStyleSel <= STYLE_PIN_STROBE;
      end
      if (state_reg == H_IDLE && take && styleSel == HBP_STYLE_MUX) begin
        bus.busStyleSel <= STYLE_PIN_DIRLINE;
        bus.addr <= cmdAddr;
      end
      if (state_reg == H_SETUP) begin
        bus.csN <= 1'h0;
        bus.addr <= addr_reg;
        bus.hostDataOe <= write_reg;
        bus.hostData <= wideSel ? data_reg : {BYTE_ZERO, data_reg[BYTE_W-1:0]};
        if (styleSel == HBP_STYLE_DIRLINE) begin
          bus.rwN <= !write_reg;
          if (wideSel) begin
            bus.addr[ADDR_LSB] <= !lanes_reg[LANE_HI];
            bus.strobeHighN <= !lanes_reg[LANE_LO];
          end else begin
            bus.strobeHighN <= 1'h0;
          end
        end else begin
          bus.rdN <= write_reg;
          bus.wrN <= !write_reg;
          if (wideSel) begin
            bus.addr[ADDR_LSB] <= !lanes_reg[LANE_LO];
            bus.strobeHighN <= !lanes_reg[LANE_HI];
          end
        end
      end
      if (state_reg == H_WAIT && !bus.ackLine) begin
        bus.csN <= PULL_LEVEL;
        bus.rdN <= PULL_LEVEL;
        bus.wrN <= PULL_LEVEL;
        bus.rwN <= PULL_LEVEL;
        bus.strobeHighN <= PULL_LEVEL;
        bus.hostDataOe <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rspValid <= 1'h0;
      rspData <= DATA_RESET;
    end else if (ce) begin
      rspValid <= 1'h0;
      if (state_reg == H_WAIT && !bus.ackLine) begin
        rspValid <= 1'h1;
        rspData <= wideSel ? bus.dataBus : {BYTE_ZERO, bus.dataBus[BYTE_W-1:0]};
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/hbp_if.sv
// Pin bundle between host and device, with pull-up resolution of shared lines
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
  import hbp_pkg::*;
  logic [DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [DATA_W-1:0] devData;
  logic devDataOe;
  logic [DATA_W-1:0] dataBus;
  logic [ADDR_W-1:0] addr;
  logic strobeHighN;
  logic rdN;
  logic wrN;
  logic rwN;
  logic csN;
  logic busStyleSel;
  logic widthSel;
  logic transferAckN;
  logic ackOe;
  logic ackLine;

  // Device wins on contention so a read is never masked
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : {DATA_W{PULL_LEVEL}});
  assign ackLine = ackOe ? transferAckN : PULL_LEVEL;

  modport device (
    input dataBus, addr, strobeHighN, rdN, wrN, rwN, csN, busStyleSel, widthSel,
    output devData, devDataOe, transferAckN, ackOe
  );
  modport host (
    input dataBus, ackLine,
    output hostData, hostDataOe, addr, strobeHighN, rdN, wrN, rwN, csN, busStyleSel, widthSel
  );
endinterface
`default_nettype wire

// >>> design/hbp_pkg.sv
// Shared constants and types for the host bus mode port
package hbp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int LANE_COUNT = 2;
  localparam int WORD_IDX_W = 7;
  localparam int WORD_COUNT = 128;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam int ADDR_LSB = 0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [LANE_COUNT-1:0] LANES_NONE = 2'h0;
  localparam logic [LANE_COUNT-1:0] LANES_LO_ONLY = 2'h1;
  localparam logic [LANE_COUNT-1:0] LANES_HI_ONLY = 2'h2;
  localparam logic [WORD_IDX_W-1:0] WORD_IDX_RESET = 7'h00;
  // Level seen on undriven lines through board pull-ups
  localparam logic PULL_LEVEL = 1'h1;
  // Bus style select sample before the first clock: low, so a static low never looks like a fall
  localparam logic STYLE_PIN_PRESET = 1'h0;
  localparam logic STYLE_PIN_DIRLINE = 1'h1;
  localparam logic STYLE_PIN_STROBE = 1'h0;

  typedef enum logic [1:0] {
    HBP_STYLE_DIRLINE,
    HBP_STYLE_STROBE,
    HBP_STYLE_MUX
  } hbp_style_t;
endpackage

// >>> verif/hbp_port_asserts.sv
// Concurrent checks on the pins between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module hbp_port_asserts
  import hbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] devData,
  input wire logic devDataOe,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic transferAckN,
  input wire logic ackOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  oe_no_write_a: assert property (devDataOe |-> wrN)
    else $error("device drives data during a write");
  oe_with_ack_a: assert property (devDataOe |-> ackOe && !transferAckN)
    else $error("device drives data outside an acknowledged access");
  read_drives_a: assert property ((ackOe && !transferAckN && !rdN && !csN) |-> devDataOe)
    else $error("acknowledged read without data on the bus");
  read_stable_a: assert property ((devDataOe && $past(devDataOe)) |-> $stable(devData))
    else $error("read data changed while driven");
  ack_needs_cs_a: assert property (($fell(transferAckN) && ackOe) |-> !$past(csN))
    else $error("acknowledge without chip select");
  ack_answer_a: assert property (
    (!csN && !(rdN && wrN) && !ackOe) |=> ackOe && !transferAckN)
    else $error("strobe not acknowledged one cycle later");
  ack_hold_a: assert property (
    (ackOe && !transferAckN && !csN && !(rdN && wrN)) |=> ackOe && !transferAckN)
    else $error("acknowledge dropped while strobe active");
  ack_release_a: assert property ($rose(csN) |-> ##[1:2] !ackOe)
    else $error("acknowledge not released after deselect");
endmodule
`default_nettype wire

// >>> verif/host_bus_mode_port_tb.sv
// Self-checking bench: host end and device end joined over the pin bundle
`timescale 1ns/1ps
`default_nettype none
`define CHK(actVal, expVal) begin \
  samplesChecked++; \
  if ((actVal) !== (expVal)) begin \
    nFail++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (actVal), (expVal)); \
  end \
end
module host_bus_mode_port_tb
  import hbp_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  hbp_style_t styleSel = HBP_STYLE_STROBE;
  logic wideSel = 1'h0;
  logic cmdValid = 1'h0;
  logic cmdWrite = 1'h0;
  logic [ADDR_W-1:0] cmdAddr = ADDR_RESET;
  logic [DATA_W-1:0] cmdData = DATA_RESET;
  logic [LANE_COUNT-1:0] cmdLanes = LANES_NONE;
  logic [WORD_IDX_W-1:0] peekIdx = WORD_IDX_RESET;
  logic cmdReady;
  logic rspValid;
  logic [DATA_W-1:0] rspData;
  logic [DATA_W-1:0] peekData;
  logic [DATA_W-1:0] got;
  hbp_style_t styleNow;
  logic wrPulse;
  logic rdPulse;
  logic [WORD_IDX_W-1:0] wrIdx;
  logic [LANE_COUNT-1:0] wrLanes;
  int wrSeen = 0;
  int rdSeen = 0;
  int nFail = 0;
  int samplesChecked = 0;

  always #2 clk = ~clk;

  // Event pulses last one cycle, so they are counted here rather than polled
  always @(posedge clk) begin
    if (wrPulse === 1'h1) begin
      wrSeen <= wrSeen + 1;
    end
    if (rdPulse === 1'h1) begin
      rdSeen <= rdSeen + 1;
    end
  end

  hbp_if hbp_if_i ();
  hbp_host_end hbp_host_end_i (.clk(clk), .rst(rst), .ce(ce), .styleSel(styleSel),
    .wideSel(wideSel), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdLanes(cmdLanes), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData), .bus(hbp_if_i));
  hbp_device_end hbp_device_end_i (.clk(clk), .rst(rst), .ce(ce), .peekIdx(peekIdx),
    .peekData(peekData), .styleNow(styleNow), .wrPulse(wrPulse), .wrIdx(wrIdx),
    .wrLanes(wrLanes), .rdPulse(rdPulse), .bus(hbp_if_i));
  hbp_port_asserts hbp_port_asserts_i (.clk(clk), .rst(rst), .devData(hbp_if_i.devData),
    .devDataOe(hbp_if_i.devDataOe), .csN(hbp_if_i.csN), .rdN(hbp_if_i.rdN),
    .wrN(hbp_if_i.wrN), .transferAckN(hbp_if_i.transferAckN), .ackOe(hbp_if_i.ackOe));

  task automatic finish_test();
    $display("Counts: %0d checked, %0d failed", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset holds the style pin and its sample at the preset level, so the style change never looks like a fall
  task automatic restart(input hbp_style_t s, input logic w);
    rst <= 1'h1;
    styleSel <= s;
    wideSel <= w;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic bus_op(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [LANE_COUNT-1:0] ln);
    int k;
    k = 0;
    cmdValid <= 1'h1;
    cmdWrite <= w;
    cmdAddr <= a;
    cmdData <= d;
    cmdLanes <= ln;
    do begin
      @(posedge clk);
      k++;
    end while (cmdReady !== 1'h1 && k < 50);
    cmdValid <= 1'h0;
    while (rspValid !== 1'h1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    got = rspData;
    if (k >= 100) begin
      nFail++;
      finish_test();
    end
  endtask

  task automatic peek(input logic [WORD_IDX_W-1:0] idx);
    peekIdx <= idx;
    repeat (3) @(posedge clk);
    got = peekData;
  endtask

  task automatic test_strobe8();
    int w0;
    int r0;
    restart(HBP_STYLE_STROBE, 1'h0);
    w0 = wrSeen;
    r0 = rdSeen;
    `CHK(styleNow, HBP_STYLE_STROBE)
    bus_op(1'h1, 8'h05, 16'h005a, LANES_LO_ONLY);
    bus_op(1'h1, 8'h04, 16'h00a5, LANES_LO_ONLY);
    bus_op(1'h0, 8'h05, DATA_RESET, LANES_LO_ONLY);
    `CHK(got, 16'h005a)
    `CHK(wrSeen - w0, 2)
    `CHK(rdSeen - r0, 1)
    peek(7'h02);
    `CHK(got, 16'h5aa5)
    `CHK(hbp_if_i.dataBus, 16'hffff)
    $display("test_strobe8 done");
  endtask

  task automatic test_strobe16();
    restart(HBP_STYLE_STROBE, 1'h1);
    bus_op(1'h1, 8'h10, 16'habcd, 2'h3);
    bus_op(1'h1, 8'h10, 16'h1234, LANES_HI_ONLY);
    `CHK(wrIdx, 7'h08)
    `CHK(wrLanes, LANES_HI_ONLY)
    bus_op(1'h0, 8'h10, DATA_RESET, 2'h3);
    `CHK(got, 16'h12cd)
    bus_op(1'h1, 8'h10, 16'h9977, LANES_LO_ONLY);
    peek(7'h08);
    `CHK(got, 16'h1277)
    $display("test_strobe16 done");
  endtask

  // Direction-line style on the 8-bit bus: one strobe, byte lane from the address LSB
  task automatic test_dirline8();
    restart(HBP_STYLE_DIRLINE, 1'h0);
    bus_op(1'h1, 8'h31, 16'h00c3, LANES_LO_ONLY);
    bus_op(1'h1, 8'h30, 16'h003c, LANES_LO_ONLY);
    bus_op(1'h0, 8'h31, DATA_RESET, LANES_LO_ONLY);
    `CHK(got, 16'h00c3)
    peek(7'h18);
    `CHK(got, 16'hc33c)
    $display("test_dirline8 done");
  endtask

  task automatic test_dirline();
    restart(HBP_STYLE_DIRLINE, 1'h1);
    `CHK(styleNow, HBP_STYLE_DIRLINE)
    bus_op(1'h1, 8'h20, 16'h0f0f, 2'h3);
    bus_op(1'h1, 8'h20, 16'h7777, LANES_LO_ONLY);
    bus_op(1'h0, 8'h20, DATA_RESET, 2'h3);
    `CHK(got, 16'h0f77)
    styleSel <= HBP_STYLE_STROBE;
    repeat (4) @(posedge clk);
    `CHK(styleNow, HBP_STYLE_MUX)
    $display("test_dirline done");
  endtask

  // Mux writes after a style change still land on the latched word
  task automatic test_mux();
    restart(HBP_STYLE_MUX, 1'h1);
    bus_op(1'h1, 8'h40, 16'hbeef, 2'h3);
    `CHK(styleNow, HBP_STYLE_MUX)
    bus_op(1'h0, 8'h40, DATA_RESET, 2'h3);
    `CHK(got, 16'hbeef)
    styleSel <= HBP_STYLE_STROBE;
    bus_op(1'h1, 8'h60, 16'h1111, 2'h3);
    peek(7'h20);
    `CHK(got, 16'h1111)
    `CHK(styleNow, HBP_STYLE_MUX)
    restart(HBP_STYLE_STROBE, 1'h0);
    `CHK(styleNow, HBP_STYLE_STROBE)
    $display("test_mux done");
  endtask

  initial begin
    test_strobe8();
    test_strobe16();
    test_dirline8();
    test_dirline();
    test_mux();
    finish_test();
  end
endmodule
`default_nettype wire
